// >>> include/scss_pkg.sv
// package: constants for the system clock source switch
package scss_pkg;
  localparam logic [11:0] CSC_OFFSET        = 12'h000;
  localparam logic [11:0] CFG_OFFSET        = 12'h004;
  localparam logic [11:0] STAT_OFFSET       = 12'h008;
  localparam logic [11:0] SLEEP_OFFSET      = 12'h00C;
  localparam int          SELECT_BIT        = 0;
  localparam int          AUXEN_BIT         = 0;
  localparam int          SWEN_N_BIT        = 1;
  localparam logic [7:0]  CSC_RESET         = 8'h00;
  localparam logic [1:0]  CFG_RESET         = 2'h2;
  localparam logic [2:0]  MODE_RESET        = 3'h1;
  localparam int          SYNC_EDGES        = 8;
  localparam int          OSC_START_CYCLES  = 1024;
  localparam int          CLK_MHZ           = 250;
  localparam int          PLL_LOCK_US       = 2000;
  localparam int          PLL_LOCK_CYCLES   = PLL_LOCK_US * CLK_MHZ;
  localparam int          PLL_MULT          = 4;
  localparam int          PIN_DIV           = 4;

  typedef enum logic [2:0]
  {
    LOW_POWER_CRYSTAL_MODE     = 3'b000,
    STANDARD_CRYSTAL_MODE      = 3'b001,
    HIGH_SPEED_CRYSTAL_MODE    = 3'b010,
    CRYSTAL_PLL_MODE           = 3'b011,
    RESISTOR_CAPACITOR_MODE    = 3'b100,
    RESISTOR_CAPACITOR_IO_MODE = 3'b101,
    EXTERNAL_CLOCK_MODE        = 3'b110,
    EXTERNAL_CLOCK_IO_MODE     = 3'b111
  } scss_mode_e;

  typedef enum logic [2:0]
  {
    RUN_PRIMARY = 3'b000,
    TO_AUX      = 3'b001,
    RUN_AUX     = 3'b010,
    START_WAIT  = 3'b011,
    PLL_WAIT    = 3'b100,
    TO_PRIMARY  = 3'b101,
    SLEEPING    = 3'b110
  } scss_state_e;
endpackage

// >>> hw/scss_switch.sv
// system clock source switch with apb control register
// Operation
// - RC mode: second oscillator pin outputs oscillator frequency divided by four.
// - RC with I/O: second oscillator pin becomes general purpose I/O.
// - external-clock modes: clock on first pin, feedback off, no start-up wait.
// - external-clock mode: second pin outputs oscillator frequency divided by four.
// - external-clock with I/O: second pin becomes general purpose I/O.
// - crystal-with-PLL mode multiplies crystal frequency by four.
// - PLL enabled only in crystal-PLL mode; otherwise clock from first pin.
// - execution held until the PLL lock timer expires; held only after a switch back or wake in crystal-PLL mode, not after reset.
// - switching allowed only when active-low switch enable is zero.
// - select bit zero picks primary oscillator, one picks auxiliary.
// - select bit cleared on arst_n reset only; a wake reset does not clear it.
// - select writes ignored and bit forced clear if aux or switch disabled.
// - control register bits seven to one read as zero.
// - count eight rising target-clock edges before using a new source.
// - freeze at next first-quarter phase, resume after eight aux cycles.
// - crystal modes: start-up wait plus eight primary cycles on switch back.
// - PLL mode: start-up wait plus PLL lock timeout on switch back.
// - RC and external modes: only eight primary cycles on switch back.
// - sleep stops all clocks and oscillator, core held at first quarter; the core freezes at once on sleep, with no wait for a first-quarter edge.
// - sleep left on external reset, watchdog reset or interrupt.
// - eight primary modes selected by a three-bit configuration field.
// - oscillator start-up wait lasts 1024 first-pin clock cycles.
`timescale 1ns/1ps
module scss_switch
  import scss_pkg::*;
#(
  parameter int PLL_LOCK_COUNT = scss_pkg::PLL_LOCK_CYCLES
)
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  oscModeConfig,
  input  wire logic        firstOscPin,
  input  wire logic        auxOscPin,
  input  wire logic        pllClk,
  input  wire logic        ioPinOut,
  input  wire logic        ioPinOe,
  input  wire logic        sleepRequest,
  input  wire logic        wakeReset,
  input  wire logic        wakeWatchdog,
  input  wire logic        wakeInterrupt,
  input  wire logic        firstQuarterPhase,
  output logic             secondOscPinOut,
  output logic             secondOscPinOe,
  output logic             feedbackEnable,
  output logic             oscEnable,
  output logic             pllEnable,
  output logic             sysClkFromPll,
  output logic             sysClkFromAux,
  output logic             coreFreeze
);
  import scss_pkg::*;

  logic [7:0]  cscReg;
  logic [1:0]  cfgReg;
  logic [2:0]  modeReg;
  scss_state_e state_reg;
  scss_state_e state_next;
  logic [1:0]  oscSync_reg;
  logic [1:0]  auxSync_reg;
  logic [1:0]  pllSync_reg;
  logic [1:0]  fqSync_reg;
  logic        oscPrev_reg;
  logic        auxPrev_reg;
  logic        fqPrev_reg;
  logic [19:0] cnt_reg;
  logic [1:0]  div_reg;
  logic        divOut_reg;
  logic        freezeArm_reg;
  logic        oscRise;
  logic        auxRise;
  logic        fqRise;
  logic        wake;
  logic        wrAccess;
  logic        sel;
  logic        auxEnable;
  logic        swEnableN;
  scss_mode_e  mode;

  function automatic logic isCrystal(input scss_mode_e m);
    return m inside {LOW_POWER_CRYSTAL_MODE, STANDARD_CRYSTAL_MODE,
                     HIGH_SPEED_CRYSTAL_MODE, CRYSTAL_PLL_MODE};
  endfunction

  assign mode      = scss_mode_e'(modeReg);
  assign sel       = cscReg[SELECT_BIT];
  assign auxEnable = cfgReg[AUXEN_BIT];
  assign swEnableN = cfgReg[SWEN_N_BIT];
  assign wrAccess  = psel & penable & pwrite;
  assign wake      = wakeReset | wakeWatchdog | wakeInterrupt;

  // two-flop synchronisers on pin-side clocks, one per pin
  // edge detectors read only the second flop
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oscSync_reg <= 2'h0;
      oscPrev_reg <= 1'b0;
    end
    else
    begin
      oscSync_reg <= {oscSync_reg[0], firstOscPin};
      oscPrev_reg <= oscSync_reg[1];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      auxSync_reg <= 2'h0;
      auxPrev_reg <= 1'b0;
    end
    else
    begin
      auxSync_reg <= {auxSync_reg[0], auxOscPin};
      auxPrev_reg <= auxSync_reg[1];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fqSync_reg <= 2'h0;
      fqPrev_reg <= 1'b0;
    end
    else
    begin
      fqSync_reg <= {fqSync_reg[0], firstQuarterPhase};
      fqPrev_reg <= fqSync_reg[1];
    end
  end

  // pll output level, kept for observation only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pllSync_reg <= 2'h0;
    else
      pllSync_reg <= {pllSync_reg[0], pllClk};
  end

  assign oscRise = oscSync_reg[1] & ~oscPrev_reg;
  assign auxRise = auxSync_reg[1] & ~auxPrev_reg;
  assign fqRise  = fqSync_reg[1] & ~fqPrev_reg;

  // mode field written through the configuration register, reset to standard crystal mode
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      modeReg <= MODE_RESET;
    else if (wrAccess && paddr == CFG_OFFSET)
      modeReg <= pwdata[4:2];
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cfgReg <= CFG_RESET;
    else if (wrAccess && paddr == CFG_OFFSET)
      cfgReg <= pwdata[1:0];
  end

  // select bit: forced clear every cycle while aux or switch disabled
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cscReg <= CSC_RESET;
    else if (auxEnable == 1'b0 || swEnableN == 1'b1)
      cscReg <= CSC_RESET;
    else if (wrAccess && paddr == CSC_OFFSET)
      cscReg <= {7'h00, pwdata[SELECT_BIT]};
  end

  // source switch sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      RUN_PRIMARY:
        if (sleepRequest)
          state_next = SLEEPING;
        else if (sel && freezeArm_reg)
          state_next = TO_AUX;
      // eight aux rises counted once, here only
      TO_AUX:
        if (cnt_reg == 20'(SYNC_EDGES))
          state_next = RUN_AUX;
      RUN_AUX:
        if (sleepRequest)
          state_next = SLEEPING;
        else if (!sel)
          state_next = isCrystal(mode) ? START_WAIT : TO_PRIMARY;
      START_WAIT:
        if (cnt_reg == 20'(OSC_START_CYCLES))
          state_next = (mode == CRYSTAL_PLL_MODE) ? PLL_WAIT : TO_PRIMARY;
      PLL_WAIT:
        if (cnt_reg == 20'(PLL_LOCK_COUNT))
          state_next = TO_PRIMARY;
      TO_PRIMARY:
        if (cnt_reg == 20'(SYNC_EDGES))
          state_next = sel ? TO_AUX : RUN_PRIMARY;
      SLEEPING:
        if (wake)
          state_next = isCrystal(mode) ? START_WAIT : TO_PRIMARY;
      default:
        state_next = RUN_PRIMARY;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= RUN_PRIMARY;
    else
      state_reg <= state_next;
  end

  // freeze arms on next first-quarter edge after select set
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      freezeArm_reg <= 1'b0;
    else if (state_reg != RUN_PRIMARY || !sel)
      freezeArm_reg <= 1'b0;
    else if (fqRise)
      freezeArm_reg <= 1'b1;
  end

  // edge / cycle counter, cleared on each state change
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= 20'h00000;
    else if (state_next != state_reg)
      cnt_reg <= 20'h00000;
    else
      unique case (state_reg)
        TO_AUX:      cnt_reg <= auxRise ? cnt_reg + 20'h00001 : cnt_reg;
        START_WAIT,
        TO_PRIMARY:  cnt_reg <= oscRise ? cnt_reg + 20'h00001 : cnt_reg;
        PLL_WAIT:    cnt_reg <= cnt_reg + 20'h00001;
        default:     cnt_reg <= cnt_reg;
      endcase
  end

  // divide-by-four of oscillator for second pin
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_reg    <= 2'h0;
      divOut_reg <= 1'b0;
    end
    else if (state_reg == SLEEPING)
    begin
      div_reg    <= 2'h0;
      divOut_reg <= 1'b0;
    end
    else if (oscRise)
    begin
      div_reg    <= div_reg + 2'h1;
      divOut_reg <= (div_reg + 2'h1) >= 2'(PIN_DIV / 2);
    end
  end

  // second pin: divided clock, general I/O or crystal feedback
  always_comb
  begin
    unique case (mode)
      RESISTOR_CAPACITOR_MODE,
      EXTERNAL_CLOCK_MODE:
      begin
        secondOscPinOut = divOut_reg;
        secondOscPinOe  = 1'b1;
      end
      RESISTOR_CAPACITOR_IO_MODE,
      EXTERNAL_CLOCK_IO_MODE:
      begin
        secondOscPinOut = ioPinOut;
        secondOscPinOe  = ioPinOe;
      end
      default:
      begin
        secondOscPinOut = 1'b0;
        secondOscPinOe  = 1'b0;
      end
    endcase
  end

  // clock routing and core freeze from sequencer state
  // core stays frozen through every wait state
  always_comb
  begin
    oscEnable      = 1'b1;
    feedbackEnable = isCrystal(mode);
    pllEnable      = mode == CRYSTAL_PLL_MODE;
    sysClkFromAux  = 1'b0;
    coreFreeze     = 1'b1;
    unique case (state_reg)
      RUN_PRIMARY:
        coreFreeze = freezeArm_reg;
      RUN_AUX:
      begin
        sysClkFromAux = 1'b1;
        coreFreeze    = 1'b0;
      end
      SLEEPING:
      begin
        oscEnable      = 1'b0;
        feedbackEnable = 1'b0;
        pllEnable      = 1'b0;
      end
      default:
        coreFreeze = 1'b1;
    endcase
    // pll clock feeds the core whenever the pll is enabled and the aux clock is not routed, including during TO_AUX
    sysClkFromPll = pllEnable && !sysClkFromAux;
  end

  // apb slave: zero-wait, unmapped reads zero with error
  assign pready = 1'b1;

  always_comb
  begin
    pslverr = psel & penable & !(paddr inside {CSC_OFFSET, CFG_OFFSET, STAT_OFFSET, SLEEP_OFFSET});
    unique case (paddr)
      CSC_OFFSET:  prdata = {24'h000000, cscReg};
      CFG_OFFSET:  prdata = {27'h0000000, modeReg, cfgReg};
      STAT_OFFSET: prdata = {28'h0000000, coreFreeze, state_reg};
      default:     prdata = 32'h00000000;
    endcase
  end
endmodule

// >>> tb/scss_switch_assertions.sv
// checker bound to the clock source switch
`timescale 1ns/1ps
module scss_switch_assertions
  import scss_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        ioPinOut,
  input wire logic        ioPinOe,
  input wire logic        secondOscPinOut,
  input wire logic        secondOscPinOe,
  input wire logic        feedbackEnable,
  input wire logic        oscEnable,
  input wire logic        pllEnable,
  input wire logic        sysClkFromAux,
  input wire logic        coreFreeze
);
  logic [4:0] cfg;
  logic       rdSel;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  assign rdSel = psel && penable && !pwrite && paddr == CSC_OFFSET;
  // shadow of the configuration register
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      cfg <= {MODE_RESET, CFG_RESET};
    else if (psel && penable && pwrite && paddr == CFG_OFFSET)
      cfg <= pwdata[4:0];
  property p_pll; pllEnable |-> cfg[4:2] == CRYSTAL_PLL_MODE; endproperty
  a_pll: assert property (p_pll) else $error("pll outside pll mode");
  property p_fb; cfg[4:3] == 2'b11 |-> !feedbackEnable; endproperty
  a_fb: assert property (p_fb) else $error("feedback on");
  property p_div; cfg[4] && !cfg[2] && oscEnable |-> secondOscPinOe; endproperty
  a_div: assert property (p_div) else $error("pin not driven");
  property p_io; cfg[4] && cfg[2] |-> {secondOscPinOut, secondOscPinOe} == {ioPinOut, ioPinOe}; endproperty
  a_io: assert property (p_io) else $error("pin not io");
  property p_rd; rdSel |-> prdata[31:1] == 31'h0; endproperty
  a_rd: assert property (p_rd) else $error("upper bits set");
  property p_frc; rdSel && (!cfg[AUXEN_BIT] || cfg[SWEN_N_BIT]) |-> !prdata[SELECT_BIT]; endproperty
  a_frc: assert property (p_frc) else $error("select not forced");
  property p_aux; $rose(sysClkFromAux) |-> $past(coreFreeze) && $past(coreFreeze, 8); endproperty
  a_aux: assert property (p_aux) else $error("aux without freeze");
  property p_slp; $fell(oscEnable) |-> coreFreeze; endproperty
  a_slp: assert property (p_slp) else $error("osc off unfrozen");
  c_aux: cover property ($rose(sysClkFromAux));
  c_back: cover property ($fell(sysClkFromAux));
  c_slp: cover property ($fell(oscEnable));
endmodule
bind scss_switch scss_switch_assertions u_chk (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .ioPinOut, .ioPinOe, .secondOscPinOut, .secondOscPinOe, .feedbackEnable, .oscEnable, .pllEnable,
  .sysClkFromAux, .coreFreeze);

// >>> tb/scss_osc_model.sv
// oscillator sources beside the clock source switch
`timescale 1ns/1ps
module scss_osc_model
(
  input wire logic ref_clk,
  input wire logic oscEnable,
  output logic     firstOscPin,
  output logic     auxOscPin,
  output logic     pllClk,
  output logic     firstQuarterPhase
);
  logic [3:0] cnt = 4'h0;
  initial
    {firstOscPin, auxOscPin, pllClk, firstQuarterPhase} = 4'h0;
  always @(posedge ref_clk)
  begin
    cnt <= cnt + 4'h1;
    auxOscPin <= cnt[3];
    firstQuarterPhase <= cnt == 4'hF;
    // primary stands still while stopped
    if (oscEnable)
    begin
      firstOscPin <= cnt[2];
      pllClk <= cnt[0];
    end
  end
endmodule

// >>> tb/scss_switch_tb_top.sv
// testbench for the clock source switch
`timescale 1ns/1ps
module scss_switch_tb_top;
  import scss_pkg::*;
  logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, err, prv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        ioPinOut, ioPinOe, sleepRequest, firstOscPin, auxOscPin, pllClk, firstQuarterPhase;
  logic        secondOscPinOut, secondOscPinOe, feedbackEnable, oscEnable, pllEnable, sysClkFromAux, coreFreeze;
  logic        sysClkFromPll;
  logic [2:0]  wake;
  int          fail_count, cmp_count, cyc, n;
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  scss_switch #(.PLL_LOCK_COUNT(16)) dut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .oscModeConfig(3'h0), .firstOscPin, .auxOscPin, .pllClk, .ioPinOut, .ioPinOe, .sleepRequest,
    .wakeReset(wake[0]), .wakeWatchdog(wake[1]), .wakeInterrupt(wake[2]), .firstQuarterPhase, .secondOscPinOut,
    .secondOscPinOe, .feedbackEnable, .oscEnable, .pllEnable, .sysClkFromPll, .sysClkFromAux, .coreFreeze);
  scss_osc_model osc (.ref_clk, .oscEnable, .firstOscPin, .auxOscPin, .pllClk, .firstQuarterPhase);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitRun(input logic v);
    n = 0;
    while (sysClkFromAux !== v || coreFreeze !== 1'b0)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ioPinOe, sleepRequest, wake, arst_n, prv} = '0;
    ioPinOut = 1'b1;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    apb(CSC_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h0, "select reset");
    apb(CSC_OFFSET, 1'b1, 32'h1);
    apb(CSC_OFFSET, 1'b0, 32'h0);
    chk(r, 32'h0, "select locked");
    $display("lock test done");
    for (int i = 0; i < 3; i++)
    begin
      apb(CFG_OFFSET, 1'b1, 32'h1 | (32'(i == 0 ? 1 : i + 2) << 2));
      apb(CSC_OFFSET, 1'b1, 32'hFF);
      apb(CSC_OFFSET, 1'b0, 32'h0);
      chk(r, 32'h1, "select set");
      waitRun(1'b1);
      chk(32'(n >= 100 && n < 400), 32'h1, "aux sync");
      apb(CSC_OFFSET, 1'b1, 32'h0);
      waitRun(1'b0);
      chk(32'(i == 2 ? n < 150 : n > (i == 1 ? 8208 : 8192)), 32'h1, "return time");
    end
    $display("switch test done");
    for (int m = 0; m < 8; m++)
    begin
      apb(CFG_OFFSET, 1'b1, 32'h2 | 32'(m << 2));
      @(posedge ref_clk);
      chk({31'h0, pllEnable}, 32'(m == 3), "pll enable");
      chk({31'h0, sysClkFromPll}, 32'(m == 3), "pll clock");
      chk({31'h0, secondOscPinOe}, 32'(m == 4 || m == 6), "pin drive");
      if (m != 4 && m != 6)
        chk({31'h0, secondOscPinOut}, 32'(m == 5 || m == 7), "pin level");
      if (m > 5)
        chk({31'h0, feedbackEnable}, 32'h0, "feedback");
    end
    apb(CFG_OFFSET, 1'b1, 32'h12);
    n = 0;
    repeat (128)
    begin
      @(posedge ref_clk);
      n += int'(secondOscPinOut & ~prv);
      prv = secondOscPinOut;
    end
    chk(32'(n >= 3 && n <= 5), 32'h1, "divided pin");
    apb(12'h010, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    $display("pin test done");
    apb(CFG_OFFSET, 1'b1, 32'h1A);
    for (int i = 0; i < 3; i++)
    begin
      sleepRequest <= 1'b1;
      while (oscEnable !== 1'b0)
        @(posedge ref_clk);
      chk({31'h0, coreFreeze}, 32'h1, "sleep freeze");
      sleepRequest <= 1'b0;
      wake <= 3'(1 << i);
      while (coreFreeze !== 1'b0)
        @(posedge ref_clk);
      chk({31'h0, oscEnable}, 32'h1, "woken");
      wake <= 3'h0;
    end
    $display("sleep test done");
    results();
  end
endmodule
